// File: dv/csl_rx_model.sv
`timescale 1ns/10ps
module csl_rx_model (
  // lane 0 watch, handshake out
  input wire logic mclk, rst, go, mf_edge,
  input wire logic [63:0] lane_octet,
  output logic link_sync_request_pin
);
  logic [2:0] run;
  assign link_sync_request_pin = !go || run == 3'h5;
  // before the fourth comma any other octet restarts the run: commas must be back to back
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) run <= 3'h0;
    else if (!go) run <= 3'h0;
    else if (run < 3'h4) run <= lane_octet[7:0] == csl_pkg::K28_5 ? run + 3'h1 : 3'h0;
    else if (mf_edge) run <= 3'h5;
  end
endmodule : csl_rx_model

// File: dv/csl_tx_properties.sv
`timescale 1ns/10ps
module csl_tx_properties #(parameter int LANES = 8) (
  // watched ports
  input wire logic mclk, rst, enc_64b66b, link_sync_request_pin, link_up,
  input wire logic fec_active, numeric_oscillator_sync,
  input wire logic [1:0] sync_header,
  input wire logic [LANES-1:0] lane_is_k, lane_active
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_cgs_k: assert property (
    (!enc_64b66b && !link_sync_request_pin && lane_active[0])[*8] |-> lane_is_k[0])
    else $error("cgs");
  a_idle_lane: assert property (!lane_active[LANES-1] |-> !lane_is_k[LANES-1])
    else $error("idle");
  a_data_k: assert property (link_up |-> lane_is_k == '0) else $error("k");
  a_hdr_mode: assert property (link_up |-> sync_header == {1'b0, enc_64b66b})
    else $error("hdr");
  a_fec_mode: assert property (fec_active |-> enc_64b66b) else $error("fec");
  a_osc_mode: assert property (numeric_oscillator_sync |-> enc_64b66b) else $error("o");
  a_osc_once: assert property (numeric_oscillator_sync |=> !numeric_oscillator_sync)
    else $error("osc");
  a_sync_ign: assert property (enc_64b66b && link_up && $fell(link_sync_request_pin)
    |=> link_up[*4]) else $error("drop");
endmodule : csl_tx_properties
bind csl_tx csl_tx_properties #(.LANES(LANES)) i_props (.*);

// File: dv/csl_tx_test.sv
`timescale 1ns/10ps
module csl_tx_test;
  logic mclk = 0, rst = 1, enc_64b66b = 0, sysref = 0, go = 0;
  logic fec_enable = 1, sync_to_oscillator = 1, link_sync_request_pin, mf_edge, link_up;
  logic fec_active, numeric_oscillator_sync;
  logic [3:0] lanes_used = 4'h4;
  logic [7:0] mf_len = 8'h07, lane_is_k, lane_active;
  logic [63:0] lane_data = 64'h0807060504030201, lane_octet;
  logic [1:0] sync_header;
  int err_total, num_checks;
  csl_tx i_dut (.*);
  csl_rx_model i_rx (.*);
  initial forever #2 mclk = ~mclk;
  initial begin
    #20000 err_total++;
    wrap_up();
  end
  task automatic chk(input logic [63:0] s, e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %0t %0h %0h", $time, s, e);
    end
  endtask : chk
  task automatic wrap_up;
    if (err_total == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic boot(input logic e);
    {rst, enc_64b66b, go, lanes_used} = {1'b1, e, 1'b0, e ? 4'h8 : 4'h4};
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    repeat (9) @(negedge mclk);
    chk({lane_active, link_up, lane_octet[7:0]}, {e ? 8'hFF : 8'h0F, 9'h0BC});
    sysref = 1'b1;
    @(negedge mclk) sysref = 1'b0;
    go = !e;
    for (int j = 0; j < 400 && link_up !== 1'b1; j++) @(negedge mclk);
  endtask : boot
  task automatic t_8b;
    boot(1'b0);
    chk({lane_active, sync_header, lane_octet[31:0]}, {10'h03C, lane_data[31:0]});
    chk(lane_is_k, 64'h0);
    go = 1'b0;
    @(negedge mclk) go = 1'b1;
    repeat (12) @(negedge mclk);
    chk({link_up, lane_octet[7:0]}, 9'h0BC);
  endtask : t_8b
  task automatic t_64b;
    boot(1'b1);
    go = 1'b1;
    repeat (20) @(negedge mclk);
    chk({lane_active, link_up, sync_header, fec_active}, 12'hFFB);
    go = 1'b0;
    repeat (3) @(negedge mclk);
    chk(numeric_oscillator_sync, 64'h1);
    @(negedge mclk);
    chk({numeric_oscillator_sync, link_up}, 64'h1);
    repeat (8) @(negedge mclk);
  endtask : t_64b
  initial begin
    t_8b();
    t_64b();
    wrap_up();
  end
endmodule : csl_tx_test

// File: hw/csl_pkg.sv
// Functional notes
// - encoding 8B/10B or 64B/66B by configuration
// - 8B/10B output stays JESD204B compatible
// - at most 8 lanes, 4 single channel
// - 64B/66B sync by header, no handshake
// - 64B/66B ignores sync, optional oscillator trigger
// - device clock runs link logic
// - sysref resets multiframe or multiblock counter
// - forward error correction option in 64B/66B
// - no 64B/80B, command channel, CRC3
// - subclass 1 only, subclass 0 receivable
// - single link lane alignment only
// - 8B/10B uses sync request pin
// - sync timing JESD204A and B compatible
// - sync low sends K28.5 on active lanes, idle octet on unused lanes
// - sync rise, wait edge, start alignment
package csl_pkg;
  // =========================================
  // character codes and sequence lengths
  localparam logic [7:0] K28_5 = 8'hBC;
  localparam logic [7:0] K28_0 = 8'h1C;
  localparam logic [7:0] K28_3 = 8'h7C;
  localparam logic [7:0] IDLE_OCTET = 8'h00;
  localparam logic [2:0] ILAS_MULTIFRAMES = 3'h4;
  localparam logic [1:0] SYNC_HEADER_DATA = 2'h1;
  localparam logic [7:0] MF_LEN_RESET = 8'h1F;
  localparam logic [3:0] LANES_RESET = 4'h8;

  typedef enum {
    CSL_WAIT_SYSREF,
    CSL_CGS,
    CSL_WAIT_EDGE,
    CSL_ILAS,
    CSL_DATA
  } csl_state_t;
endpackage : csl_pkg

// File: hw/csl_tx.sv
`timescale 1ns/10ps
module csl_tx #(
  parameter int LANES = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // configuration
  input wire logic enc_64b66b,
  input wire logic fec_enable,
  input wire logic [3:0] lanes_used,
  input wire logic [7:0] mf_len,
  input wire logic sync_to_oscillator,
  // pins from the far side
  input wire logic link_sync_request_pin,
  input wire logic sysref,
  // lane data in
  input wire logic [LANES*8-1:0] lane_data,
  // lane outputs
  output logic [LANES*8-1:0] lane_octet,
  output logic [LANES-1:0] lane_is_k,
  output logic [LANES-1:0] lane_active,
  output logic [1:0] sync_header,
  output logic fec_active,
  output logic mf_edge,
  output logic link_up,
  output logic numeric_oscillator_sync
);
  // =========================================
  // state
  typedef struct packed {
    logic [1:0] sync_s;
    logic [1:0] sref_s;
    logic sync_q;
    logic sref_q;
    logic sref_seen;
    logic [7:0] mf_cnt;
    logic [2:0] ilas_mf;
    csl_pkg::csl_state_t st;
    logic [LANES*8-1:0] octet;
    logic [LANES-1:0] is_k;
    logic [LANES-1:0] act;
    logic [1:0] hdr;
    logic fec;
    logic edge_o;
    logic up;
    logic osc;
  } csl_regs_t;

  csl_regs_t r;
  csl_regs_t next_r;
  logic edge_now;
  logic sync_rise;
  logic sref_rise;
  logic [3:0] lim;

  // =========================================
  // next state
  always_comb begin
    next_r = r;
    // pins pass two flops before anything reads them
    next_r.sync_s = {r.sync_s[0], link_sync_request_pin};
    next_r.sref_s = {r.sref_s[0], sysref};
    next_r.sync_q = r.sync_s[1];
    next_r.sref_q = r.sref_s[1];
    sync_rise = r.sync_s[1] & ~r.sync_q;
    sref_rise = r.sref_s[1] & ~r.sref_q;
    // lane count clipped to the build width
    lim = (lanes_used > 4'(LANES)) ? 4'(LANES) : lanes_used;
    // one counter serves multiframe or extended multiblock
    edge_now = (r.mf_cnt == 8'h00);
    if (sref_rise) begin
      next_r.mf_cnt = mf_len;
      next_r.sref_seen = 1'b1;
    end else if (edge_now) begin
      next_r.mf_cnt = mf_len;
    end else begin
      next_r.mf_cnt = r.mf_cnt - 8'h01;
    end
    // sync only feeds the oscillator in 64B/66B
    next_r.osc = enc_64b66b & sync_to_oscillator & sync_rise;
    case (r.st)
      csl_pkg::CSL_WAIT_SYSREF: begin
        if (r.sref_seen) next_r.st = csl_pkg::CSL_CGS;
      end
      csl_pkg::CSL_CGS: begin
        if (enc_64b66b) next_r.st = csl_pkg::CSL_DATA;
        else if (sync_rise) next_r.st = csl_pkg::CSL_WAIT_EDGE;
      end
      csl_pkg::CSL_WAIT_EDGE: begin
        if (edge_now) begin
          next_r.st = csl_pkg::CSL_ILAS;
          next_r.ilas_mf = 3'h0;
        end
      end
      csl_pkg::CSL_ILAS: begin
        if (edge_now) begin
          next_r.ilas_mf = r.ilas_mf + 3'h1;
          if (r.ilas_mf == csl_pkg::ILAS_MULTIFRAMES - 3'h1) next_r.st = csl_pkg::CSL_DATA;
        end
      end
      csl_pkg::CSL_DATA: ;
      default: next_r.st = csl_pkg::CSL_WAIT_SYSREF;
    endcase
    // receiver asking again restarts alignment
    if (!enc_64b66b && !r.sync_s[1] && r.st != csl_pkg::CSL_WAIT_SYSREF) begin
      next_r.st = csl_pkg::CSL_CGS;
    end
    next_r.edge_o = edge_now;
    next_r.up = (r.st == csl_pkg::CSL_DATA);
    next_r.fec = enc_64b66b & fec_enable;
    next_r.hdr = enc_64b66b ? csl_pkg::SYNC_HEADER_DATA : 2'h0;
    for (int i = 0; i < LANES; i++) begin
      next_r.act[i] = (4'(i) < lim);
      if (4'(i) >= lim) begin
        next_r.octet[i*8 +: 8] = csl_pkg::IDLE_OCTET;
        next_r.is_k[i] = 1'b0;
      end else if (r.st == csl_pkg::CSL_DATA) begin
        next_r.octet[i*8 +: 8] = lane_data[i*8 +: 8];
        next_r.is_k[i] = 1'b0;
      end else if (r.st == csl_pkg::CSL_ILAS && !enc_64b66b) begin
        // 8B/10B framing kept JESD204B style
        next_r.is_k[i] = (r.mf_cnt == mf_len) | edge_now;
        next_r.octet[i*8 +: 8] = (r.mf_cnt == mf_len) ? csl_pkg::K28_0 :
                                 edge_now ? csl_pkg::K28_3 : lane_data[i*8 +: 8];
      end else begin
        next_r.octet[i*8 +: 8] = csl_pkg::K28_5;
        next_r.is_k[i] = 1'b1;
      end
    end
  end

  // =========================================
  // registers, all on the device clock
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.st <= csl_pkg::CSL_WAIT_SYSREF;
      r.mf_cnt <= csl_pkg::MF_LEN_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign lane_octet = r.octet;
  assign lane_is_k = r.is_k;
  assign lane_active = r.act;
  assign sync_header = r.hdr;
  assign fec_active = r.fec;
  assign mf_edge = r.edge_o;
  assign link_up = r.up;
  assign numeric_oscillator_sync = r.osc;
  // subclass 1 only; no 64B/80B, command channel, CRC3 or multipoint
endmodule : csl_tx
